/* design/pdss_pkg.sv */
// pdss_pkg: constants, register map and state encoding of the slot sequencer
// assumes a 100 MHz system clock and an apb slave with 32-bit data
//
// Summary of operation
// - up to 32 sequenced ids, each pointing at a slot, grouped in three domains
// - base domain slots 1..end1, second end1+1..end2, third end2+1..max count
// - reload enable restores voltages, timer and domain enables at power-up start
// - all ids on one slot are processed together in the same cycle
// - a slot with no ids is a dummy step with its own delay
// - ids pointing above max count are never touched by the sequencer
// - slot 0 with default enable: manual ids get stay-on set, others enabled
// - ids enabled during power-up select their first voltage register
// - power-down slot 0: clear non-stay-on ids, others switch to second voltage
// - default enable cleared: slot 0 skipped, its ids unchanged
// - auto boot and base enable: assert ready, then process slot 1
// - without auto boot hold until base enable, or wake if already enabled
// - slots from 1 processed like slot 0 without the default enable effect
// - at end1 without second enable: stop, release ready, raise done event
// - after base domain wait for second enable, assert ready, run to end2
// - at end2 without third enable: release ready, raise done, start watchdog
// - third enable from pin, register or stored config runs slots to max count
// - ready held while third domain runs; done event at max count
// - with clock output enabled pause at oscillator slot until it is stable
// - wait id holds progress until the monitored input is active
// - slot delay 32 us to 8 ms, default 128 us; dummy delay separate
// - power-down walks slots in reverse, ready asserted, done event at target
package pdss_pkg;

  localparam int unsigned NUM_IDS     = 32;
  localparam int unsigned SLOT_W      = 5;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned TICK_US     = 32;                      // delay unit
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;        // 3200 cycles
  localparam int unsigned DELAY_W     = 8;                        // 1..250 ticks
  localparam logic [7:0]  DELAY_MIN   = 8'h01;                    // 32 us
  localparam logic [7:0]  DELAY_MAX   = 8'hFA;                    // 8 ms
  localparam logic [7:0]  DELAY_RST   = 8'h04;                    // 128 us

  // fixed id positions of special steps
  localparam int unsigned WAIT_ID = 29;
  localparam int unsigned OSC_ID  = 30;
  localparam int unsigned PDS_ID  = 31;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] PTR_OFS       = 12'h004;
  localparam logic [11:0] TIMER_OFS     = 12'h008;
  localparam logic [11:0] STATUS_OFS    = 12'h00C;
  localparam logic [11:0] AUTO_OFS      = 12'h010;
  localparam logic [11:0] STAY_OFS      = 12'h014;
  localparam logic [11:0] ENABLE_OFS    = 12'h018;
  localparam logic [11:0] VSEL_OFS      = 12'h01C;
  localparam logic [11:0] SLOT_BASE_OFS = 12'h080;                // 32 words, 0x080..0x0FC

  // control register bits
  localparam int unsigned CTRL_BASE_EN   = 0;
  localparam int unsigned CTRL_SECOND_EN = 1;
  localparam int unsigned CTRL_THIRD_EN  = 2;
  localparam int unsigned CTRL_AUTO_BOOT = 3;
  localparam int unsigned CTRL_DEF_SLOT0 = 4;
  localparam int unsigned CTRL_RELOAD    = 5;
  localparam int unsigned CTRL_NO_DOM_RD = 6;
  localparam int unsigned CTRL_READY_SEL = 7;
  localparam int unsigned CTRL_EVT_EN    = 8;
  localparam int unsigned CTRL_CLK_OUT   = 9;
  localparam int unsigned CTRL_W         = 10;
  localparam logic [9:0]  CTRL_RST       = 10'h390;

  // pointer register reset: end1=4, end2=8, max=12, partial down=2
  localparam logic [19:0] PTR_RST = 20'h6_2082;

  typedef enum logic [2:0] {
    PDSS_IDLE   = 3'b000,
    PDSS_START  = 3'b001,
    PDSS_STEP   = 3'b011,
    PDSS_DELAY  = 3'b010,
    PDSS_PAUSE  = 3'b110,
    PDSS_DOWN   = 3'b111,
    PDSS_DDELAY = 3'b101
  } pdss_state_e;

endpackage : pdss_pkg

/* design/pdss_sequencer.sv */
// pdss_sequencer: slot based power domain sequencer with an apb register file
// assumes apb master on clk_sys; domain enable pins and status inputs are synchronous
//
// Added by the designer: the address map and the APB interface to the registers.
module pdss_sequencer
#(
  parameter int unsigned TICK_CYCLES = pdss_pkg::TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // host domain enable pins and wake-up
  input  wire logic        base_domain_enable_pin,
  input  wire logic        second_domain_enable_pin,
  input  wire logic        third_domain_enable_pin,
  input  wire logic        wake_event,
  // status inputs
  input  wire logic        osc_stable,
  input  wire logic        wait_input_active,
  // stored configuration for reload
  input  wire logic [2:0]  stored_domain_enables,
  input  wire logic [15:0] stored_slot_delays,
  input  wire logic        stored_voltages_load,
  // outputs
  output logic [31:0]      id_enable,
  output logic [31:0]      id_voltage_second,
  output logic             ready_out,
  output logic             sequence_done_event,
  output logic             watchdog_start,
  output logic             voltage_reload,
  output logic             powerdown_settings_active
);

  // register storage
  logic [pdss_pkg::CTRL_W-1:0] ctrl;
  logic [19:0]                 ptrs;
  logic [7:0]                  slot_delay_setting;
  logic [7:0]                  dummy_slot_delay_setting;
  logic [31:0]                 auto_bits;
  logic [31:0]                 stay_on_bits;
  logic [4:0]                  slot_of [pdss_pkg::NUM_IDS];

  // sequencer state
  pdss_pkg::pdss_state_e state;
  logic [4:0]            slot;
  logic [4:0]            target;
  logic [7:0]            delay_left;
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
  logic                  tick;
  logic                  going_down;
  logic                  wake_seen;

  // pointer fields
  logic [4:0] partial_down_ptr;
  logic [4:0] base_end_ptr;
  logic [4:0] second_end_ptr;
  logic [4:0] max_count_ptr;
  assign partial_down_ptr = ptrs[4:0];
  assign base_end_ptr     = ptrs[9:5];
  assign second_end_ptr   = ptrs[14:10];
  assign max_count_ptr    = ptrs[19:15];

  // domain enables: pin or register bit
  logic base_en;
  logic second_en;
  logic third_en;
  assign base_en   = ctrl[pdss_pkg::CTRL_BASE_EN]   | base_domain_enable_pin;
  assign second_en = ctrl[pdss_pkg::CTRL_SECOND_EN] | second_domain_enable_pin;
  assign third_en  = ctrl[pdss_pkg::CTRL_THIRD_EN]  | third_domain_enable_pin;

  // ids that point at a given slot, all matched in one cycle
  function automatic logic [31:0] ids_at(input logic [4:0] s, input logic [4:0] sl [pdss_pkg::NUM_IDS]);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < pdss_pkg::NUM_IDS; i++)
      m[i] = (sl[i] == s);
    return m;
  endfunction : ids_at

  // highest slot the current enables allow
  function automatic logic [4:0] reach(input logic b, input logic s2, input logic s3,
                                       input logic [4:0] e1, input logic [4:0] e2, input logic [4:0] mx);
    logic [4:0] r;
    r = 5'h00;
    if (b) r = e1;
    if (b && s2) r = e2;
    if (b && s2 && s3) r = mx;
    return r;
  endfunction : reach

  logic [31:0] here;
  logic        hold;
  logic [4:0]  goal;
  assign here = ids_at(slot, slot_of);
  assign goal = reach(base_en, second_en, third_en, base_end_ptr, second_end_ptr, max_count_ptr);
  // oscillator and wait ids stall progress while their condition is not met
  assign hold = (here[pdss_pkg::OSC_ID] && ctrl[pdss_pkg::CTRL_CLK_OUT] && !osc_stable)
              || (here[pdss_pkg::WAIT_ID] && !wait_input_active);

  // apb: zero wait states, unmapped addresses read zero and flag an error
  logic wr;
  logic mapped;
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign mapped  = (paddr[11:2] <= 10'h007) || (paddr[11:7] == 5'h01);
  assign pslverr = psel && penable && !mapped;

  // read mux, registered to keep data outputs off the decode
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      unique case (paddr)
        pdss_pkg::CTRL_OFS:   prdata <= {22'h0, ctrl};
        pdss_pkg::PTR_OFS:    prdata <= {12'h0, ptrs};
        pdss_pkg::TIMER_OFS:  prdata <= {16'h0, dummy_slot_delay_setting, slot_delay_setting};
        pdss_pkg::STATUS_OFS: prdata <= {16'h0, 3'h0, going_down, ready_out, state, 3'h0, slot};
        pdss_pkg::AUTO_OFS:   prdata <= auto_bits;
        pdss_pkg::STAY_OFS:   prdata <= stay_on_bits;
        pdss_pkg::ENABLE_OFS: prdata <= id_enable;
        pdss_pkg::VSEL_OFS:   prdata <= id_voltage_second;
        default:              prdata <= (paddr[11:7] == 5'h01) ? {27'h0, slot_of[paddr[6:2]]} : 32'h0000_0000;
      endcase
    end
  end

  // start condition out of the holding state; a high base pin counts as its own wake
  logic next_start_go;
  assign next_start_go = base_en && (ctrl[pdss_pkg::CTRL_AUTO_BOOT] || wake_seen || base_domain_enable_pin);

  // stored-configuration reload happens on every step out of power down, whatever started it
  logic reload_now;
  assign reload_now = (state == pdss_pkg::PDSS_START) && next_start_go && ctrl[pdss_pkg::CTRL_RELOAD];

  // control and timer registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl                     <= pdss_pkg::CTRL_RST;
      ptrs                     <= pdss_pkg::PTR_RST;
      slot_delay_setting       <= pdss_pkg::DELAY_RST;
      dummy_slot_delay_setting <= pdss_pkg::DELAY_RST;
    end
    else if (reload_now)
    begin
      slot_delay_setting       <= stored_slot_delays[7:0];
      dummy_slot_delay_setting <= stored_slot_delays[15:8];
      if (!ctrl[pdss_pkg::CTRL_NO_DOM_RD])
        ctrl[2:0] <= stored_domain_enables;
    end
    else if (wr)
    begin
      if (paddr == pdss_pkg::CTRL_OFS)
        ctrl <= pwdata[pdss_pkg::CTRL_W-1:0];
      if (paddr == pdss_pkg::PTR_OFS)
        ptrs <= pwdata[19:0];
      if (paddr == pdss_pkg::TIMER_OFS)
      begin
        // out-of-range delays clamp so a slot never lasts zero time
        slot_delay_setting       <= (pwdata[7:0] < pdss_pkg::DELAY_MIN) ? pdss_pkg::DELAY_MIN :
                                    (pwdata[7:0] > pdss_pkg::DELAY_MAX) ? pdss_pkg::DELAY_MAX : pwdata[7:0];
        dummy_slot_delay_setting <= (pwdata[15:8] < pdss_pkg::DELAY_MIN) ? pdss_pkg::DELAY_MIN :
                                    (pwdata[15:8] > pdss_pkg::DELAY_MAX) ? pdss_pkg::DELAY_MAX : pwdata[15:8];
      end
    end
  end

  // per-id configuration words
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      auto_bits <= 32'hFFFF_FFFF;
      for (int i = 0; i < pdss_pkg::NUM_IDS; i++)
        slot_of[i] <= 5'h1F;
    end
    else if (wr)
    begin
      if (paddr == pdss_pkg::AUTO_OFS)
        auto_bits <= pwdata;
      if (paddr[11:7] == 5'h01)
        slot_of[paddr[6:2]] <= pwdata[4:0];
    end
  end

  // 32 us time base
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= (tick_cnt == '0);
      tick_cnt <= (tick_cnt == '0) ? ($bits(tick_cnt))'(TICK_CYCLES - 1) : tick_cnt - 1'b1;
    end
  end

  // wake events latch while waiting at start; set wins over the clear
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wake_seen <= 1'b0;
    else if (wake_event)
      wake_seen <= 1'b1;
    else if (state != pdss_pkg::PDSS_START)
      wake_seen <= 1'b0;
  end

  // in range ids: slot 1..max count
  logic [31:0] in_range;
  always_comb
  begin
    for (int i = 0; i < pdss_pkg::NUM_IDS; i++)
      in_range[i] = (slot_of[i] != 5'h00) && (slot_of[i] <= max_count_ptr);
  end

  // main sequencing state machine
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= pdss_pkg::PDSS_IDLE;
      slot       <= 5'h00;
      target     <= 5'h00;
      delay_left <= 8'h00;
      going_down <= 1'b0;
    end
    else
    begin
      unique case (state)
        pdss_pkg::PDSS_IDLE:
          state <= pdss_pkg::PDSS_START;
        pdss_pkg::PDSS_START:
        begin
          slot       <= 5'h00;
          going_down <= 1'b0;
          // auto boot with base enable proceeds; otherwise wait for the enable or a wake
          if (base_en && (ctrl[pdss_pkg::CTRL_AUTO_BOOT] || wake_seen || base_domain_enable_pin))
          begin
            slot  <= 5'h01;
            state <= pdss_pkg::PDSS_STEP;
          end
        end
        pdss_pkg::PDSS_STEP:
        begin
          if (!hold)
          begin
            // dummy slots take their own delay
            delay_left <= (here == 32'h0) ? dummy_slot_delay_setting : slot_delay_setting;
            state      <= pdss_pkg::PDSS_DELAY;
          end
        end
        pdss_pkg::PDSS_DELAY:
        begin
          if (tick)
            delay_left <= delay_left - 8'h01;
          if (tick && delay_left == 8'h01)
          begin
            if (slot < goal)
            begin
              slot  <= slot + 5'h01;
              state <= pdss_pkg::PDSS_STEP;
            end
            else
              state <= pdss_pkg::PDSS_PAUSE;
          end
        end
        pdss_pkg::PDSS_PAUSE:
        begin
          if (slot < goal)
          begin
            slot  <= slot + 5'h01;
            state <= pdss_pkg::PDSS_STEP;
          end
          else if (slot > goal)
          begin
            target     <= (!base_en) ? 5'h00 : goal;
            going_down <= 1'b1;
            state      <= pdss_pkg::PDSS_DOWN;
          end
        end
        pdss_pkg::PDSS_DOWN:
        begin
          delay_left <= (here == 32'h0) ? dummy_slot_delay_setting : slot_delay_setting;
          state      <= pdss_pkg::PDSS_DDELAY;
        end
        pdss_pkg::PDSS_DDELAY:
        begin
          if (tick)
            delay_left <= delay_left - 8'h01;
          if (tick && delay_left == 8'h01)
          begin
            if (slot > target)
            begin
              slot  <= slot - 5'h01;
              state <= pdss_pkg::PDSS_DOWN;
            end
            else
            begin
              going_down <= 1'b0;
              state      <= (slot == 5'h00) ? pdss_pkg::PDSS_START : pdss_pkg::PDSS_PAUSE;
            end
          end
        end
        default:
          state <= pdss_pkg::PDSS_IDLE;
      endcase
    end
  end

  // id outputs: processing happens on entry into each slot
  logic step_up;
  logic step_down;
  logic slot0_up;
  assign step_up   = (state == pdss_pkg::PDSS_STEP) && !hold;
  // the target slot of a partial power-down belongs to the domain that stays up
  assign step_down = (state == pdss_pkg::PDSS_DOWN) && (slot > target);
  assign slot0_up  = (state == pdss_pkg::PDSS_START) && (next_start_go) && ctrl[pdss_pkg::CTRL_DEF_SLOT0];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      id_enable         <= 32'h0000_0000;
      id_voltage_second <= 32'h0000_0000;
      stay_on_bits      <= 32'h0000_0000;
    end
    else
    begin
      if (wr && paddr == pdss_pkg::ENABLE_OFS)
        id_enable <= (id_enable & in_range) | (pwdata & ~in_range);
      if (wr && paddr == pdss_pkg::STAY_OFS)
        stay_on_bits <= pwdata;
      if (slot0_up)
      begin
        // slot 0 power-up: manual ids get stay-on set but no enable
        stay_on_bits      <= stay_on_bits | (ids_at(5'h00, slot_of) & ~auto_bits);
        id_enable         <= id_enable | (ids_at(5'h00, slot_of) & auto_bits);
        id_voltage_second <= id_voltage_second & ~ids_at(5'h00, slot_of);
      end
      else if (step_up)
      begin
        id_enable         <= id_enable | (here & in_range);
        id_voltage_second <= id_voltage_second & ~(here & in_range);
      end
      else if (step_down)
      begin
        id_enable <= id_enable & ~(here & in_range & ~stay_on_bits);
        id_voltage_second <= id_voltage_second | (here & in_range & stay_on_bits);
      end
      else if (state == pdss_pkg::PDSS_DDELAY && slot == 5'h00 && ctrl[pdss_pkg::CTRL_DEF_SLOT0])
      begin
        // slot 0 on the way down, skipped when default enable is clear
        id_enable         <= id_enable & ~(ids_at(5'h00, slot_of) & ~stay_on_bits);
        id_voltage_second <= id_voltage_second | (ids_at(5'h00, slot_of) & stay_on_bits);
      end
    end
  end

  // ready, done event, watchdog start, reload and power-down settings
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ready_out                 <= 1'b0;
      sequence_done_event       <= 1'b0;
      watchdog_start            <= 1'b0;
      voltage_reload            <= 1'b0;
      powerdown_settings_active <= 1'b0;
    end
    else
    begin
      voltage_reload <= reload_now && stored_voltages_load;
      sequence_done_event <= 1'b0;
      watchdog_start      <= 1'b0;
      if ((state == pdss_pkg::PDSS_START && next_start_go) || state == pdss_pkg::PDSS_DOWN
          || (state == pdss_pkg::PDSS_PAUSE && slot < goal))
        ready_out <= ctrl[pdss_pkg::CTRL_READY_SEL];
      if ((state == pdss_pkg::PDSS_DELAY || state == pdss_pkg::PDSS_DDELAY)
          && tick && delay_left == 8'h01 && !(state == pdss_pkg::PDSS_DELAY && slot < goal)
          && !(state == pdss_pkg::PDSS_DDELAY && slot > target))
      begin
        // release ready unless the third domain keeps it up
        if (!(slot == second_end_ptr && third_en) || slot == max_count_ptr)
          ready_out <= 1'b0;
        sequence_done_event <= ctrl[pdss_pkg::CTRL_EVT_EN];
        watchdog_start      <= (state == pdss_pkg::PDSS_DELAY) && (slot == second_end_ptr);
      end
      if (step_up && here[pdss_pkg::PDS_ID])
        powerdown_settings_active <= 1'b0;
      else if (step_down && here[pdss_pkg::PDS_ID])
        powerdown_settings_active <= 1'b1;
    end
  end

endmodule : pdss_sequencer

/* bench/pdss_sequencer_monitor.sv */
// pdss_sequencer_monitor: port level checks of the slot sequencer
// assumes binding onto pdss_sequencer, single clk_sys domain
module pdss_sequencer_monitor
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // sequencer outputs
  input wire logic [31:0] id_enable,
  input wire logic [31:0] id_voltage_second,
  input wire logic        ready_out,
  input wire logic        sequence_done_event,
  input wire logic        watchdog_start,
  input wire logic        voltage_reload
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // an error answer only exists inside an access phase
  err_in_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  ctrl_mapped_a: assert property (psel && penable && paddr == pdss_pkg::CTRL_OFS |-> !pslverr)
    else $error("control word refused");
  hole_refused_a: assert property (psel && penable && paddr == 12'hFFC |-> pslverr && pready)
    else $error("unmapped word accepted");
  done_pulse_a: assert property (sequence_done_event |=> !sequence_done_event)
    else $error("done event longer than one cycle");
  wd_pulse_a: assert property (watchdog_start |=> !watchdog_start)
    else $error("watchdog start longer than one cycle");
  reload_pulse_a: assert property (voltage_reload |=> !voltage_reload)
    else $error("reload longer than one cycle");
  // slots from 1 on are at least two cycles apart; slot 0 and slot 1 can change enables on consecutive cycles
  slot_pace_a: assert property (id_enable != $past(id_enable) |=> $stable(id_enable))
    else $error("enables changed on consecutive cycles");
  first_volt_a: assert property ((id_enable & ~$past(id_enable)) != 32'h0 |->
    (id_voltage_second & id_enable & ~$past(id_enable)) == 32'h0)
    else $error("new enable on second voltage");

  cover property (sequence_done_event);
  cover property (watchdog_start);
  cover property ($rose(ready_out));
  cover property (pslverr);
endmodule : pdss_sequencer_monitor

bind pdss_sequencer pdss_sequencer_monitor pdss_sequencer_monitor_inst (.*);

/* bench/pdss_host_model.sv */
// pdss_host_model: host side of the domain enable pins and status inputs
// assumes the bench asks for domain levels on want; pins follow after lag+1 cycles
module pdss_host_model
#(
  parameter int unsigned LAG = 3
)
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // requested domain levels {third, second, base}
  input wire logic [2:0] want,
  // pins toward the sequencer
  output logic           base_pin,
  output logic           second_pin,
  output logic           third_pin,
  output logic           osc_ok,
  output logic           wait_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;

  // a slow host: the pins move only after the request has stood lag+1 cycles
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {third_pin, second_pin, base_pin} <= 3'h0;
      cnt                               <= 0;
    end
    else if (want != {third_pin, second_pin, base_pin})
    begin
      cnt <= cnt + 1;
      if (cnt == LAG)
      begin
        {third_pin, second_pin, base_pin} <= want;
        cnt                               <= 0;
      end
    end
    else
      cnt <= 0;
  end

  // oscillator settles one cycle after reset; host alive once base is up
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      {osc_ok, wait_ok} <= 2'h0;
    else
      {osc_ok, wait_ok} <= {1'b1, base_pin};
  end
endmodule : pdss_host_model

/* bench/pdss_sequencer_bench.sv */
// pdss_sequencer_bench: apb driven power-up and power-down of three domains
// assumes a short tick (4 cycles) so slot delays stay small
module pdss_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, id_enable, rd;
  logic        base_pin, second_pin, third_pin, osc_ok, wait_ok, ready_out, done_ev, wd_start;
  logic [2:0]  want;
  logic        wake, vld, vload, vseen;
  logic [15:0] sdly;
  int          errors, checked;

  pdss_sequencer #(.TICK_CYCLES(4)) pdss_sequencer_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .base_domain_enable_pin(base_pin),
    .second_domain_enable_pin(second_pin), .third_domain_enable_pin(third_pin), .wake_event(wake),
    .osc_stable(osc_ok), .wait_input_active(wait_ok), .stored_domain_enables(3'h0),
    .stored_slot_delays(sdly), .stored_voltages_load(vld), .id_enable(id_enable),
    .id_voltage_second(), .ready_out(ready_out), .sequence_done_event(done_ev),
    .watchdog_start(wd_start), .voltage_reload(vload), .powerdown_settings_active());

  pdss_host_model #(.LAG(3)) pdss_host_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .want(want),
    .base_pin(base_pin), .second_pin(second_pin), .third_pin(third_pin), .osc_ok(osc_ok),
    .wait_ok(wait_ok));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // remembers a reload pulse until the test that expects it looks
  always @(posedge clk_sys)
    if (vload === 1'b1)
      vseen <= 1'b1;

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  // bounded wait for a one-cycle pulse, then let outputs settle
  task automatic wait_ev(input string n, input bit wd);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < 3000 && !hit; i++)
    begin
      @(posedge clk_sys);
      hit = wd ? (wd_start === 1'b1) : (done_ev === 1'b1);
    end
    chk(n, 32'h1, {31'h0, hit});
    repeat (2) @(posedge clk_sys);
  endtask : wait_ev

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, want, wake, vseen} = '0;
    {sdly, vld} = {16'h0302, 1'b1};
    reset_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk("id_enable", 32'h0, id_enable);
    apb(1'b0, pdss_pkg::CTRL_OFS, 32'h0, rd);
    chk("ctrl", {22'h0, pdss_pkg::CTRL_RST}, rd);
    apb(1'b0, 12'hFFC, 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test reset and map done");
    apb(1'b1, pdss_pkg::TIMER_OFS, 32'h0, rd);
    apb(1'b0, pdss_pkg::TIMER_OFS, 32'h0, rd);
    chk("delay low", 32'h01, {24'h0, rd[7:0]});
    apb(1'b1, pdss_pkg::TIMER_OFS, 32'hFF, rd);
    apb(1'b0, pdss_pkg::TIMER_OFS, 32'h0, rd);
    chk("delay high", 32'hFA, {24'h0, rd[7:0]});
    apb(1'b1, pdss_pkg::TIMER_OFS, 32'h0101, rd);
    $display("test delay clamp done");
    // end1=1, end2=2, max=3; ids 0..2 on slots 1..3, the rest stay out of range
    apb(1'b1, pdss_pkg::PTR_OFS, 32'h0001_8820, rd);
    for (int i = 0; i < 3; i++)
      apb(1'b1, pdss_pkg::SLOT_BASE_OFS + 12'(4 * i), 32'(i + 1), rd);
    want <= 3'b001;
    apb(1'b1, pdss_pkg::CTRL_OFS, 32'h398, rd);
    wait_ev("base done", 1'b0);
    chk("base ids", 32'h1, id_enable);
    chk("ready base", 32'h0, {31'h0, ready_out});
    want <= 3'b011;
    wait_ev("watchdog start", 1'b1);
    chk("second ids", 32'h3, id_enable);
    chk("ready second", 32'h0, {31'h0, ready_out});
    want <= 3'b111;
    wait_ev("third done", 1'b0);
    chk("third ids", 32'h7, id_enable);
    $display("test power up done");
    want <= 3'b000;
    wait_ev("down done", 1'b0);
    chk("down ids", 32'h0, id_enable);
    $display("test power down done");
    // base enabled by register, no auto boot: hold at start until a wake event
    apb(1'b1, pdss_pkg::CTRL_OFS, 32'h3F1, rd);
    repeat (20) @(posedge clk_sys);
    chk("held at start", 32'h0, id_enable);
    chk("no early reload", 32'h0, {31'h0, vseen});
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    wait_ev("wake done", 1'b0);
    chk("wake ids", 32'h1, id_enable);
    chk("reload pulse", 32'h1, {31'h0, vseen});
    apb(1'b0, pdss_pkg::TIMER_OFS, 32'h0, rd);
    chk("reloaded delays", 32'h0302, {16'h0, rd[15:0]});
    $display("test reload and wake done");
    report_and_stop;
  end

  // the whole run needs well under this many cycles
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    errors++;
    report_and_stop;
  end
endmodule : pdss_sequencer_bench
